// file: design/fpel_flash_controller.v
// Operation
// - page-write with one modified word runs the shortened word program
// - page-write with several modified words runs the full page program
// - erase touching a locked region is refused whole, lock error set
// - erase-all clears the whole plane; no code fetched meanwhile
// - argument 1:0 selects 4, 8, 16 or 32 pages with sector limits
// - sector erase clears the sector holding the argument page
// - fetches during multi-page or sector erase stall until it ends
// - erase starts the cycle after a valid erase command is written while idle
// - erase end sets ready and raises interrupt when enabled
// - erase reports command error on bad key, flash error on verify
// - set-lock locks the region of the argument page
// - clear-lock unlocks the region of the argument page
// - get-lock result reads return lock words in order, then zero
// - bit n of returned lock words is one when region n is locked
// - flash reads stay serviced during lock commands
// - lock commands report command error and flash verify error
// - every command carries the key in the top eight bits
// - command write clears ready and result value until completion
// - command and lock error flags clear on status read
`timescale 1ns/1ps
`include "fpel_defines.vh"

module fpel_flash_controller (
    input  wire        clk,               // system clock
    input  wire        reset,             // synchronous, active high
    input  wire [7:0]  reg_addr,          // register byte address
    input  wire [31:0] reg_wdata,         // register write data
    input  wire        reg_write,         // write strobe
    input  wire        reg_read,          // read strobe
    output reg  [31:0] reg_rdata,         // read data, cycle after read
    output wire        ready_irq,         // ready interrupt line
    input  wire        fetch_req,         // processor fetch from flash
    output wire        fetch_stall,       // hold the fetch
    input  wire [31:0] latch_dirty,       // modified 128-bit latch words
    output reg         latch_reinit,      // reset latch buffer to ones
    output reg         flash_op_start,    // one-cycle operation start
    output reg  [2:0]  flash_op_code,     // operation kind
    output reg  [15:0] flash_op_page,     // first page or lock region
    output reg  [16:0] flash_op_count,    // number of pages
    input  wire        flash_op_done,     // operation finished pulse
    input  wire        flash_verify_fail  // verify failed, with done
);

    localparam ST_IDLE   = 2'h0;
    localparam ST_RUN    = 2'h1;
    localparam ST_FINISH = 2'h2;

    reg  [1:0]  state;
    reg         mode_ready_ie;
    reg         ready_flag;
    reg         command_error_flag;
    reg         lock_error_flag;
    reg         flash_error_flag;
    reg  [`FPEL_LOCK_REGIONS-1:0] lock_bits;
    reg         result_valid;
    reg  [1:0]  result_index;

    wire        multi_word;

    wire [7:0]  command_code     = reg_wdata[`FPEL_CODE_MSB:`FPEL_CODE_LSB];
    wire [15:0] command_argument = reg_wdata[`FPEL_ARG_MSB:`FPEL_ARG_LSB];
    wire [7:0]  command_key      = reg_wdata[`FPEL_KEY_MSB:`FPEL_KEY_LSB];

    wire cmd_write  = reg_write && (reg_addr == `FPEL_OFS_COMMAND);
    wire mode_write = reg_write && (reg_addr == `FPEL_OFS_MODE);
    wire stat_read  = reg_read && (reg_addr == `FPEL_OFS_STATUS);
    wire res_read   = reg_read && (reg_addr == `FPEL_OFS_RESULT);

    // true when any region overlapping [first, first+cnt) is locked
    function lock_hit;
        input [15:0] first;
        input [16:0] cnt;
        input [`FPEL_LOCK_REGIONS-1:0] locks;
        reg   [16:0] lo;
        reg   [16:0] hi;
        reg   [16:0] rs;
        integer      i;
        begin
            lock_hit = 1'b0;
            lo = {1'b0, first};
            hi = lo + cnt;
            for (i = 0; i < `FPEL_LOCK_REGIONS; i = i + 1)
            begin
                rs = {i[12:0], 4'h0};
                if (locks[i] && (rs < hi) && (rs + `FPEL_REGION_PAGES > lo))
                    lock_hit = 1'b1;
            end
        end
    endfunction

    // page count selected by argument bits 1:0
    function [16:0] span_count;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    span_count = 17'h0_0004;
                2'h1:    span_count = 17'h0_0008;
                2'h2:    span_count = 17'h0_0010;
                default: span_count = 17'h0_0020;
            endcase
        end
    endfunction

    fpel_word_count u_word_count (
        .dirty_mask (latch_dirty),
        .multi_word (multi_word)
    );

    // command decode, evaluated for a write arriving while idle
    reg         dec_cmd_err;
    reg         dec_lock_err;
    reg         dec_start;
    reg         dec_get_lock;
    reg  [2:0]  dec_op;
    reg  [15:0] dec_page;
    reg  [16:0] dec_count;
    reg  [15:0] span_first;
    reg  [16:0] span_cnt;

    always @*
    begin
        dec_cmd_err  = 1'b0;
        dec_lock_err = 1'b0;
        dec_start    = 1'b0;
        dec_get_lock = 1'b0;
        dec_op       = `FPEL_OP_NONE;
        dec_page     = 16'h0000;
        dec_count    = 17'h0_0000;
        span_first   = {2'b00, command_argument[15:2]};
        span_cnt     = span_count(command_argument[1:0]);
        if (command_key != `FPEL_CMD_KEY)
            dec_cmd_err = 1'b1;
        else
        begin
            case (command_code)
                `FPEL_CMD_WRITE_PAGE:
                begin
                    dec_page  = command_argument;
                    dec_count = 17'h0_0001;
                    dec_op    = multi_word ? `FPEL_OP_PAGE_PROG
                                           : `FPEL_OP_WORD_PROG;
                end
                `FPEL_CMD_ERASE_ALL:
                begin
                    dec_page  = 16'h0000;
                    dec_count = `FPEL_NUM_PAGES;
                    dec_op    = `FPEL_OP_ERASE;
                end
                `FPEL_CMD_MULTI_PAGE:
                begin
                    dec_page  = span_first;
                    dec_count = span_cnt;
                    dec_op    = `FPEL_OP_ERASE;
                    // small counts only in small sectors, 32 never there
                    if ((command_argument[1] == 1'b0) &&
                        (span_first >= `FPEL_FIRST_SECT_END))
                        dec_cmd_err = 1'b1;
                    if ((command_argument[1:0] == 2'h3) &&
                        (span_first < `FPEL_FIRST_SECT_END))
                        dec_cmd_err = 1'b1;
                    if (({1'b0, span_first} & (span_cnt - 17'h0_0001))
                        != 17'h0_0000)
                        dec_cmd_err = 1'b1;
                end
                `FPEL_CMD_SECTOR:
                begin
                    dec_page  = {command_argument[15:7], 7'h00};
                    dec_count = 17'h0_0080;
                    dec_op    = `FPEL_OP_ERASE;
                end
                `FPEL_CMD_SET_LOCK:
                begin
                    dec_page = {10'h000, command_argument[9:4]};
                    dec_op   = `FPEL_OP_LOCK_SET;
                end
                `FPEL_CMD_CLEAR_LOCK:
                begin
                    dec_page = {10'h000, command_argument[9:4]};
                    dec_op   = `FPEL_OP_LOCK_CLR;
                end
                `FPEL_CMD_GET_LOCK:
                    dec_get_lock = 1'b1;
                default:
                    dec_cmd_err = 1'b1;
            endcase
        end
        // program and erase are refused whole over a locked region
        if (!dec_cmd_err && (dec_op == `FPEL_OP_ERASE ||
            dec_op == `FPEL_OP_WORD_PROG || dec_op == `FPEL_OP_PAGE_PROG))
        begin
            if (lock_hit(dec_page, dec_count, lock_bits))
                dec_lock_err = 1'b1;
        end
        dec_start = !dec_cmd_err && !dec_lock_err &&
                    (dec_op != `FPEL_OP_NONE);
    end

    // commands written while busy are dropped
    wire cmd_accept = cmd_write && (state == ST_IDLE);
    wire op_end     = (state == ST_RUN) && flash_op_done;

    // sequencer
    always @(posedge clk)
    begin
        if (reset)
        begin
            state          <= ST_IDLE;
            ready_flag     <= `FPEL_RST_READY;
            flash_op_start <= 1'b0;
            flash_op_code  <= `FPEL_OP_NONE;
            flash_op_page  <= 16'h0000;
            flash_op_count <= 17'h0_0000;
            latch_reinit   <= 1'b0;
        end
        else
        begin
            flash_op_start <= 1'b0;
            latch_reinit   <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (cmd_accept)
                    begin
                        ready_flag <= 1'b0;
                        if (dec_start)
                        begin
                            flash_op_start <= 1'b1;
                            flash_op_code  <= dec_op;
                            flash_op_page  <= dec_page;
                            flash_op_count <= dec_count;
                            state          <= ST_RUN;
                        end
                        else
                            state <= ST_FINISH;
                    end
                end
                ST_RUN:
                begin
                    if (flash_op_done)
                    begin
                        if (flash_op_code == `FPEL_OP_WORD_PROG ||
                            flash_op_code == `FPEL_OP_PAGE_PROG)
                            latch_reinit <= 1'b1;
                        state <= ST_FINISH;
                    end
                end
                ST_FINISH:
                begin
                    ready_flag    <= 1'b1;
                    flash_op_code <= `FPEL_OP_NONE;
                    state         <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // lock bits change only after a clean lock-storage write
    always @(posedge clk)
    begin
        if (reset)
            lock_bits <= {`FPEL_LOCK_REGIONS{1'b0}};
        else if (op_end && !flash_verify_fail)
        begin
            if (flash_op_code == `FPEL_OP_LOCK_SET)
                lock_bits[flash_op_page[5:0]] <= 1'b1;
            else if (flash_op_code == `FPEL_OP_LOCK_CLR)
                lock_bits[flash_op_page[5:0]] <= 1'b0;
        end
    end

    // status flags: a new event wins over the read-clear
    wire set_cmd_err  = cmd_accept && dec_cmd_err;
    wire set_lock_err = cmd_accept && dec_lock_err;

    always @(posedge clk)
    begin
        if (reset)
        begin
            command_error_flag <= 1'b0;
            lock_error_flag    <= 1'b0;
            flash_error_flag   <= 1'b0;
            mode_ready_ie      <= `FPEL_RST_MODE;
        end
        else
        begin
            command_error_flag <= set_cmd_err ||
                (command_error_flag && !stat_read);
            lock_error_flag    <= set_lock_err ||
                (lock_error_flag && !stat_read);
            if (op_end && flash_verify_fail)
                flash_error_flag <= 1'b1;
            else if (cmd_accept)
                flash_error_flag <= 1'b0;
            if (mode_write)
                mode_ready_ie <= reg_wdata[`FPEL_MODE_READY_IE];
        end
    end

    // get-lock result words
    always @(posedge clk)
    begin
        if (reset)
        begin
            result_valid <= 1'b0;
            result_index <= 2'h0;
        end
        else if (cmd_accept)
        begin
            result_valid <= dec_get_lock && !dec_cmd_err;
            result_index <= 2'h0;
        end
        else if (res_read && result_valid && ready_flag &&
                 result_index != `FPEL_RESULT_WORDS)
            result_index <= result_index + 2'h1;
    end

    // read data, one cycle after the strobe
    always @(posedge clk)
    begin
        if (reset)
            reg_rdata <= 32'h0000_0000;
        else if (reg_read)
        begin
            case (reg_addr)
                `FPEL_OFS_MODE:
                    reg_rdata <= {31'h0000_0000, mode_ready_ie};
                `FPEL_OFS_STATUS:
                    reg_rdata <= {28'h000_0000, flash_error_flag,
                                  lock_error_flag, command_error_flag,
                                  ready_flag};
                `FPEL_OFS_RESULT:
                begin
                    if (!result_valid || !ready_flag)
                        reg_rdata <= 32'h0000_0000;
                    else if (result_index == 2'h0)
                        reg_rdata <= lock_bits[31:0];
                    else if (result_index == 2'h1)
                        reg_rdata <= lock_bits[63:32];
                    else
                        reg_rdata <= 32'h0000_0000;
                end
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    assign ready_irq = ready_flag && mode_ready_ie;

    // erase and program hold fetches; lock operations let reads through
    assign fetch_stall = fetch_req && (state == ST_RUN) &&
        (flash_op_code == `FPEL_OP_ERASE ||
         flash_op_code == `FPEL_OP_WORD_PROG ||
         flash_op_code == `FPEL_OP_PAGE_PROG);

endmodule

// file: design/fpel_word_count.v
`timescale 1ns/1ps
`include "fpel_defines.vh"

// flags more than one modified 128-bit word in the latch buffer
module fpel_word_count (
    input  wire [`FPEL_WORDS_PER_PAGE-1:0] dirty_mask, // one bit per word
    output reg                             multi_word  // more than one word
);

    integer i;
    reg     seen;

    always @*
    begin
        seen = 1'b0;
        multi_word = 1'b0;
        for (i = 0; i < `FPEL_WORDS_PER_PAGE; i = i + 1)
        begin
            if (dirty_mask[i])
            begin
                if (seen)
                    multi_word = 1'b1;
                seen = 1'b1;
            end
        end
    end

endmodule

// file: inc/fpel_defines.vh
`ifndef FPEL_DEFINES_VH
`define FPEL_DEFINES_VH

// register offsets on the plain register port
`define FPEL_OFS_MODE      8'h00
`define FPEL_OFS_COMMAND   8'h04
`define FPEL_OFS_STATUS    8'h08
`define FPEL_OFS_RESULT    8'h0C

// command_reg field layout
`define FPEL_CODE_MSB      7
`define FPEL_CODE_LSB      0
`define FPEL_ARG_MSB       23
`define FPEL_ARG_LSB       8
`define FPEL_KEY_MSB       31
`define FPEL_KEY_LSB       24
// protection key, value arbitrary
`define FPEL_CMD_KEY       8'hC3

// command codes
`define FPEL_CMD_WRITE_PAGE  8'h01
`define FPEL_CMD_ERASE_ALL   8'h05
`define FPEL_CMD_MULTI_PAGE  8'h07
`define FPEL_CMD_SET_LOCK    8'h08
`define FPEL_CMD_CLEAR_LOCK  8'h09
`define FPEL_CMD_GET_LOCK    8'h0A
`define FPEL_CMD_SECTOR      8'h11

// status_reg bit positions
`define FPEL_ST_READY      0
`define FPEL_ST_CMD_ERR    1
`define FPEL_ST_LOCK_ERR   2
`define FPEL_ST_FLASH_ERR  3
// mode_reg bit positions
`define FPEL_MODE_READY_IE 0

// reset values
`define FPEL_RST_MODE      1'b0
`define FPEL_RST_READY     1'b1

// array geometry
`define FPEL_NUM_PAGES       17'h0_0400
`define FPEL_LOCK_REGIONS    64
`define FPEL_REGION_SHIFT    4
`define FPEL_REGION_PAGES    17'h0_0010
`define FPEL_FIRST_SECT_END  16'h0080
`define FPEL_WORDS_PER_PAGE  32
`define FPEL_RESULT_WORDS    2'h2

// operation codes toward the array
`define FPEL_OP_NONE       3'h0
`define FPEL_OP_WORD_PROG  3'h1
`define FPEL_OP_PAGE_PROG  3'h2
`define FPEL_OP_ERASE      3'h3
`define FPEL_OP_LOCK_SET   3'h4
`define FPEL_OP_LOCK_CLR   3'h5

`endif

// file: testbench/fpel_array_model.sv
`timescale 1ns/1ps

module fpel_array_model (
    input  wire clk,   // clock
    input  wire reset, // reset
    input  wire start, // op start pulse
    input  wire slow,  // long operation
    input  wire fail,  // verify fails
    output reg  done,  // op finished
    output wire vfail  // verify result
);
    reg [7:0] left;
    reg       busy;
    // meaningless off the done cycle, so it keeps moving
    assign vfail = done ? fail : left[0];
    always @(posedge clk)
    begin
        done <= 1'b0;
        left <= left + 8'h01;
        if (reset)
            busy <= 1'b0;
        else if (start)
        begin
            busy <= 1'b1;
            left <= slow ? 8'h28 : 8'h03;
        end
        else if (busy)
        begin
            left <= left - 8'h01;
            busy <= left != 8'h00;
            done <= left == 8'h00;
        end
    end
endmodule

// file: testbench/fpel_flash_controller_bench.sv
`timescale 1ns/1ps
`include "fpel_defines.vh"

module fpel_flash_controller_bench;
    localparam [7:0] K = `FPEL_CMD_KEY;
    reg         clk, reset, reg_write, reg_read, fetch_req, slow, fail;
    reg         ie, irq_s;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata, latch_dirty, st;
    reg  [13:0] pg;
    wire [31:0] reg_rdata;
    wire        ready_irq, fetch_stall, reinit, op_start, op_done, vfail;
    wire [2:0]  op_code;
    wire [15:0] op_page;
    wire [16:0] op_count;
    reg  [2:0]  c_code;
    reg  [15:0] c_page;
    reg  [16:0] c_count;
    integer     err_total = 0, num_checks = 0, n_start = 0, cyc = 0, i;
    integer     n_reinit = 0, n_stall = 0;

    fpel_flash_controller i_dut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .ready_irq(ready_irq),
        .fetch_req(fetch_req), .fetch_stall(fetch_stall),
        .latch_dirty(latch_dirty), .latch_reinit(reinit),
        .flash_op_start(op_start), .flash_op_code(op_code),
        .flash_op_page(op_page), .flash_op_count(op_count),
        .flash_op_done(op_done), .flash_verify_fail(vfail));
    fpel_array_model i_arr (.clk(clk), .reset(reset), .start(op_start),
        .slow(slow), .fail(fail), .done(op_done), .vfail(vfail));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (reinit)
            n_reinit = n_reinit + 1;
        if (fetch_stall)
            n_stall = n_stall + 1;
        if (op_start)
        begin
            n_start = n_start + 1;
            c_code = op_code;
            c_page = op_page;
            c_count = op_count;
        end
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            final_report;
        end
    end

    task chk(input string n, input [31:0] e, input [31:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, output [31:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        irq_s = ready_irq;
        @(posedge clk);
    end
    endtask
    // command and lock errors clear on each status read, so they are gathered over the poll
    task cmd(input [7:0] k, input [7:0] c, input [15:0] a,
             input [31:0] exp_st, input integer ns);
        integer n0, j;
        reg [31:0] acc;
    begin
        n0 = n_start;
        acc = 32'h0;
        st = 32'h0;
        wr(`FPEL_OFS_COMMAND, {k, a, c});
        for (j = 0; j < 200 && st[0] !== 1'b1; j = j + 1)
        begin
            rd(`FPEL_OFS_STATUS, st);
            acc = acc | st;
        end
        chk("status", exp_st, {acc[31:1], st[0]});
        chk("starts", ns, n_start - n0);
        chk("irq", ie, irq_s);
    end
    endtask
    task final_report;
    begin
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    initial
    begin
        reset <= 1'b1;
        {reg_addr, reg_wdata, reg_write, reg_read, latch_dirty} <= 0;
        {fetch_req, slow, fail} <= 0;
        {ie, irq_s} = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(`FPEL_OFS_STATUS, st);
        chk("status", 32'h1, st);
        rd(`FPEL_OFS_MODE, st);
        chk("mode", 32'h0, st);
        wr(`FPEL_OFS_MODE, 32'h1);
        ie = 1'b1;
        fetch_req <= 1'b1;
        // one aligned word, then two adjacent aligned words
        latch_dirty <= 32'h0000_0004;
        cmd(K, `FPEL_CMD_WRITE_PAGE, 16'h0005, 32'h1, 1);
        chk("code", `FPEL_OP_WORD_PROG, c_code);
        latch_dirty <= 32'h0000_0030;
        cmd(K, `FPEL_CMD_WRITE_PAGE, 16'h0005, 32'h1, 1);
        chk("code", `FPEL_OP_PAGE_PROG, c_code);
        chk("reinit", 2, n_reinit);
        for (i = 0; i < 4; i = i + 1)
        begin
            pg = (i < 2) ? 14'd8 : (i == 2) ? 14'd16 : 14'd256;
            cmd(K, `FPEL_CMD_MULTI_PAGE, {pg, i[1:0]}, 32'h1, 1);
            chk("count", 17'h4 << i, c_count);
            chk("page", pg, c_page);
        end
        cmd(K, `FPEL_CMD_MULTI_PAGE, {14'd0, 2'd3}, 32'h3, 0);
        cmd(K, `FPEL_CMD_MULTI_PAGE, {14'd128, 2'd0}, 32'h3, 0);
        cmd(K, `FPEL_CMD_MULTI_PAGE, {14'd130, 2'd2}, 32'h3, 0);
        cmd(8'h3C, `FPEL_CMD_ERASE_ALL, 16'h0, 32'h3, 0);
        cmd(K, 8'h03, 16'h0, 32'h3, 0);
        rd(`FPEL_OFS_STATUS, st);
        chk("status", 32'h1, st);
        wr(`FPEL_OFS_MODE, 32'h0);
        ie = 1'b0;
        i = n_stall;
        cmd(K, `FPEL_CMD_SET_LOCK, 16'd40, 32'h1, 1);
        chk("stall", i, n_stall);
        chk("region", 40 / 16, c_page);
        cmd(K, `FPEL_CMD_SET_LOCK, 16'd980, 32'h1, 1);
        cmd(K, `FPEL_CMD_WRITE_PAGE, 16'd40, 32'h5, 0);
        chk("reinit", 2, n_reinit);
        cmd(K, `FPEL_CMD_GET_LOCK, 16'h0, 32'h1, 0);
        rd(`FPEL_OFS_RESULT, st);
        chk("lock0", 32'h1 << (40 / 16), st);
        rd(`FPEL_OFS_RESULT, st);
        chk("lock1", 32'h1 << (980 / 16 - 32), st);
        rd(`FPEL_OFS_RESULT, st);
        chk("lock2", 32'h0, st);
        cmd(K, `FPEL_CMD_MULTI_PAGE, {14'd32, 2'd2}, 32'h5, 0);
        cmd(K, `FPEL_CMD_MULTI_PAGE, {14'd960, 2'd3}, 32'h5, 0);
        cmd(K, `FPEL_CMD_ERASE_ALL, 16'h0, 32'h5, 0);
        cmd(K, `FPEL_CMD_SECTOR, 16'd10, 32'h5, 0);
        fail <= 1'b1;
        cmd(K, `FPEL_CMD_CLEAR_LOCK, 16'd40, 32'h9, 1);
        fail <= 1'b0;
        cmd(K, `FPEL_CMD_GET_LOCK, 16'h0, 32'h1, 0);
        rd(`FPEL_OFS_RESULT, st);
        chk("lock0", 32'h1 << (40 / 16), st);
        cmd(K, `FPEL_CMD_CLEAR_LOCK, 16'd40, 32'h1, 1);
        cmd(K, `FPEL_CMD_CLEAR_LOCK, 16'd980, 32'h1, 1);
        chk("code", `FPEL_OP_LOCK_CLR, c_code);
        fail <= 1'b1;
        i = n_stall;
        cmd(K, `FPEL_CMD_SECTOR, 16'd300, 32'h9, 1);
        chk("stall", i + 6, n_stall);
        chk("page", 16'd256, c_page);
        chk("count", 17'd128, c_count);
        fail <= 1'b0;
        slow <= 1'b1;
        wr(`FPEL_OFS_COMMAND, {K, 16'h0, `FPEL_CMD_ERASE_ALL});
        cmd(K, `FPEL_CMD_SECTOR, 16'd300, 32'h1, 1);
        chk("count", 17'h0_0400, c_count);
        final_report;
    end
endmodule

// file: testbench/fpel_flash_controller_monitor.sv
`timescale 1ns/1ps
`include "fpel_defines.vh"

module fpel_cm (
    input wire        clk,            // clock
    input wire        reset,          // reset
    input wire [7:0]  reg_addr,       // address
    input wire [31:0] reg_wdata,      // write data
    input wire        reg_write,      // write strobe
    input wire        ready_irq,      // irq
    input wire        fetch_req,      // fetch
    input wire        fetch_stall,    // stall
    input wire [31:0] latch_dirty,    // dirty words
    input wire        flash_op_start, // op start
    input wire [2:0]  flash_op_code,  // op kind
    input wire [15:0] flash_op_page,  // op page
    input wire [16:0] flash_op_count, // op pages
    input wire        flash_op_done   // op done
);
    reg       busy;
    reg [2:0] kind;
    reg       ie;
    wire      lock_op = kind == `FPEL_OP_LOCK_SET || kind == `FPEL_OP_LOCK_CLR;
    wire      st = flash_op_start;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always @(posedge clk)
    begin
        busy <= reset ? 1'b0 : st ? 1'b1 : flash_op_done ? 1'b0 : busy;
        kind <= st ? flash_op_code : kind;
        ie <= reset ? 1'b0 : (reg_write && reg_addr == `FPEL_OFS_MODE) ?
              reg_wdata[0] : ie;
    end
    sequence s_keyed;
        $past(reg_write) && $past(reg_addr) == `FPEL_OFS_COMMAND &&
        $past(reg_wdata[31:24]) == `FPEL_CMD_KEY;
    endsequence
    sequence s_end;
        busy && flash_op_done && ie;
    endsequence
    a_start_keyed: assert property (st |-> s_keyed)
        else $error("op start without keyed write");
    a_word_single: assert property (st && flash_op_code == `FPEL_OP_WORD_PROG
        |-> $countones($past(latch_dirty)) <= 1)
        else $error("word program with several words");
    a_page_multi: assert property (st && flash_op_code == `FPEL_OP_PAGE_PROG
        |-> $countones($past(latch_dirty)) > 1)
        else $error("page program with one word");
    a_multi_range: assert property (st &&
        $past(reg_wdata[7:0]) == `FPEL_CMD_MULTI_PAGE |->
        flash_op_count == (17'h4 << $past(reg_wdata[9:8])) &&
        flash_op_page == {2'b00, $past(reg_wdata[23:10])})
        else $error("multi-page range wrong");
    a_sector_base: assert property (st &&
        $past(reg_wdata[7:0]) == `FPEL_CMD_SECTOR |->
        flash_op_count == 17'h80 &&
        flash_op_page == {$past(reg_wdata[23:15]), 7'h00})
        else $error("sector range wrong");
    a_lock_region: assert property (st &&
        flash_op_code inside {`FPEL_OP_LOCK_SET, `FPEL_OP_LOCK_CLR} |->
        flash_op_page == {10'h000, $past(reg_wdata[17:12])})
        else $error("lock region wrong");
    a_erase_all: assert property (st &&
        $past(reg_wdata[7:0]) == `FPEL_CMD_ERASE_ALL |->
        flash_op_count == 17'h0_0400 && flash_op_page == 16'h0000)
        else $error("erase-all range wrong");
    a_erase_stall: assert property (busy && kind == `FPEL_OP_ERASE &&
        fetch_req && !flash_op_done |-> fetch_stall)
        else $error("fetch not stalled in erase");
    a_lock_fetch: assert property (busy && lock_op |-> !fetch_stall)
        else $error("fetch stalled in lock op");
    a_busy_quiet: assert property (busy |-> !st && !ready_irq)
        else $error("new op or ready while busy");
    a_irq_end: assert property (s_end |-> ##2 ready_irq)
        else $error("no interrupt after op end");
endmodule

bind fpel_flash_controller fpel_cm i_mon (.clk, .reset, .reg_addr,
    .reg_wdata, .reg_write, .ready_irq, .fetch_req, .fetch_stall,
    .latch_dirty, .flash_op_start, .flash_op_code, .flash_op_page,
    .flash_op_count, .flash_op_done);
